// File: hw/pmcs_map.vh
`ifndef PMCS_MAP_VH
`define PMCS_MAP_VH
// register word addresses (avalon word index)
`define PMCS_ADDR_MODE 2'h0
`define PMCS_ADDR_AUX 2'h1
`define PMCS_ADDR_STAT 2'h2
// clock_mode_control fields
`define PMCS_IDLE_BIT 7
`define PMCS_FREQ_HI 6
`define PMCS_FREQ_LO 4
`define PMCS_PRIACT_BIT 3
`define PMCS_INTSTB_BIT 2
`define PMCS_SRC_HI 1
`define PMCS_SRC_LO 0
// aux control fields
`define PMCS_AUX_SECEN_BIT 0
`define PMCS_AUX_LFSRC_BIT 1
`define PMCS_AUX_WDT_BIT 2
`define PMCS_AUX_FSCM_BIT 3
`define PMCS_AUX_PRIINT_BIT 4
// status fields
`define PMCS_STAT_SECACT_BIT 6
`define PMCS_STAT_SLEEP_BIT 1
`define PMCS_STAT_IDLE_BIT 0
// reset values
`define PMCS_MODE_RST 8'h00
`define PMCS_AUX_RST 8'h00
// switch timing: old-source cycles, new-source cycles
`define PMCS_OLD_CYC 3'h2
`define PMCS_NEW_CYC 3'h4
`endif

// File: hw/pmcs_top.v
// Summary of operation
// - bit 7 idles CPU, bits 1:0 pick source
// - run modes clock CPU and peripherals
// - sleep stops CPU, peripheral, primary and fast clocks; idle stops CPU
// - source write switches at once if running
// - sleep samples idle bit at execution
// - switch takes two old, four new cycles
// - status flags name active clock source
// - internal primary may show both flags
// - reset enters primary run, primary flag set
// - select 01 moves to secondary, primary off
// - secondary disabled blocks switch, not running waits
// - back to primary waits, secondary keeps running
// - hardware never rewrites software select fields
// - upper select bit enters internal run
// - frequency writes act immediately on internal
// - zero frequency keeps fast oscillator off unless aux bit 1 (LFSRC) is set
// - nonzero frequency enables fast osc, flag after
// - internal to primary waits for primary ready
// - slow source kept for watchdog or monitor
//
// Implementation choices: the register offsets and register access over Avalon-MM.
module pmcs_top (
  input wire i_core_clk,
  input wire i_rstn,
  input wire [1:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_sleep_exec,
  input wire i_wake,
  input wire i_pri_ready,
  input wire i_sec_running,
  input wire i_fast_stable,
  output reg o_pri_osc_en,
  output reg o_sec_osc_en,
  output reg o_fast_osc_en,
  output reg o_slow_src_en,
  output reg [1:0] o_clk_sel,
  output reg [2:0] o_freq_sel,
  output reg o_cpu_clk_en,
  output reg o_per_clk_en
);
`include "pmcs_map.vh"

  // source encodings of the glitch-free mux
  localparam [1:0] SRC_PRI = 2'h0;
  localparam [1:0] SRC_SEC = 2'h1;
  localparam [1:0] SRC_INT = 2'h2;

  // one-hot switch sequencer
  localparam [3:0] ST_STEADY = 4'h1;
  localparam [3:0] ST_WAIT = 4'h2;
  localparam [3:0] ST_OLD = 4'h4;
  localparam [3:0] ST_NEW = 4'h8;

  // maps the select field to a source; upper bit wins, lower ignored
  function [1:0] src_of;
    input [1:0] sel;
    begin
      src_of = sel[1] ? SRC_INT : (sel[0] ? SRC_SEC : SRC_PRI);
    end
  endfunction

  // oscillator indications come from other domains: three-stage sync
  reg [2:0] pri_sync_reg;
  reg [2:0] sec_sync_reg;
  reg [2:0] fast_sync_reg;
  reg pri_rdy_reg;
  reg secondary_run_reg;
  reg fast_stb_reg;
  reg [7:0] mode_reg;
  reg [4:0] aux_reg;
  reg [3:0] state_reg;
  reg [1:0] cur_src_reg;
  reg [1:0] tgt_src_reg;
  reg [2:0] cnt_reg;
  reg sleep_reg;
  reg idle_reg;
  reg pri_act_reg;
  reg sec_act_reg;
  reg int_stb_reg;
  reg fast_was_on_reg;
  reg mux_on_reg;

  wire [1:0] want_src = src_of(mode_reg[`PMCS_SRC_HI:`PMCS_SRC_LO]);
  wire [2:0] freq = mode_reg[`PMCS_FREQ_HI:`PMCS_FREQ_LO];
  wire fast_req = (freq != 3'h0) || aux_reg[`PMCS_AUX_LFSRC_BIT];
  wire pri_int = aux_reg[`PMCS_AUX_PRIINT_BIT];
  wire acc = (i_avs_read || i_avs_write) && o_avs_waitrequest;

  // target source ready: the secondary needs only its synced running flag
  wire tgt_ok = (tgt_src_reg == SRC_PRI) ? pri_rdy_reg :
                (tgt_src_reg == SRC_SEC) ? secondary_run_reg : 1'b1;

  // synchronisers: change counts once stages two and three agree
  // primary counts as ready out of reset, so its flag is not dropped after release
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pri_sync_reg <= 3'h7;
      sec_sync_reg <= 3'h0;
      fast_sync_reg <= 3'h0;
      pri_rdy_reg <= 1'b1;
      secondary_run_reg <= 1'b0;
      fast_stb_reg <= 1'b0;
    end else begin
      pri_sync_reg <= {pri_sync_reg[1:0], i_pri_ready};
      sec_sync_reg <= {sec_sync_reg[1:0], i_sec_running};
      fast_sync_reg <= {fast_sync_reg[1:0], i_fast_stable};
      if (pri_sync_reg[1] == pri_sync_reg[2])
        pri_rdy_reg <= pri_sync_reg[2];
      if (sec_sync_reg[1] == sec_sync_reg[2])
        secondary_run_reg <= sec_sync_reg[2];
      if (fast_sync_reg[1] == fast_sync_reg[2])
        fast_stb_reg <= fast_sync_reg[2];
    end
  end

  // avalon slave: one wait cycle, then answer; hardware never writes mode fields
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
      mode_reg <= `PMCS_MODE_RST;
      aux_reg <= 5'h00;
    end else begin
      o_avs_waitrequest <= !acc;
      if (acc && i_avs_write) begin
        case (i_avs_address)
          `PMCS_ADDR_MODE: begin
            // status bits 3:2 are read-only
            mode_reg[7:4] <= i_avs_writedata[7:4];
            mode_reg[1:0] <= i_avs_writedata[1:0];
          end
          `PMCS_ADDR_AUX: aux_reg <= i_avs_writedata[4:0];
          default: ;
        endcase
      end
      if (acc && i_avs_read) begin
        case (i_avs_address)
          `PMCS_ADDR_MODE:
            o_avs_readdata <= {24'h0, mode_reg[7:4], pri_act_reg, int_stb_reg,
                               mode_reg[1:0]};
          `PMCS_ADDR_AUX: o_avs_readdata <= {27'h0, aux_reg};
          `PMCS_ADDR_STAT:
            o_avs_readdata <= {24'h0, 1'b0, sec_act_reg, 4'h0, sleep_reg, idle_reg};
          default: o_avs_readdata <= 32'h0;
        endcase
      end else begin
        o_avs_readdata <= 32'h0;
      end
    end
  end

  // switch sequencer: wait for target, gate old clock, let new one settle
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_STEADY;
      cur_src_reg <= SRC_PRI;
      tgt_src_reg <= SRC_PRI;
      cnt_reg <= 3'h0;
      mux_on_reg <= 1'b1;
    end else begin
      case (state_reg)
        ST_STEADY: begin
          mux_on_reg <= 1'b1;
          // a disabled secondary is refused outright
          if (want_src != cur_src_reg &&
              !(want_src == SRC_SEC && !aux_reg[`PMCS_AUX_SECEN_BIT])) begin
            tgt_src_reg <= want_src;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // old source keeps clocking while the new one starts
          if (tgt_ok) begin
            cnt_reg <= 3'h0;
            state_reg <= ST_OLD;
          end else if (src_of(mode_reg[1:0]) == cur_src_reg) begin
            state_reg <= ST_STEADY;
          end
        end
        ST_OLD: begin
          mux_on_reg <= 1'b0; // gated low: no runt pulse on the mux output
          if (cnt_reg == `PMCS_OLD_CYC - 3'h1) begin
            cnt_reg <= 3'h0;
            cur_src_reg <= tgt_src_reg;
            state_reg <= ST_NEW;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        ST_NEW: begin
          if (cnt_reg == `PMCS_NEW_CYC - 3'h1) begin
            mux_on_reg <= 1'b1;
            state_reg <= ST_STEADY;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        default: state_reg <= ST_STEADY;
      endcase
    end
  end

  // sleep entry samples the idle bit at that instant; wake returns to run
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sleep_reg <= 1'b0;
      idle_reg <= 1'b0;
    end else if (i_wake) begin
      sleep_reg <= 1'b0;
      idle_reg <= 1'b0;
    end else if (i_sleep_exec && !sleep_reg && !idle_reg) begin
      sleep_reg <= !mode_reg[`PMCS_IDLE_BIT];
      idle_reg <= mode_reg[`PMCS_IDLE_BIT];
    end
  end

  // status flags change only when the sequencer is steady on a source, or in sleep
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pri_act_reg <= 1'b1;
      sec_act_reg <= 1'b0;
      int_stb_reg <= 1'b0;
      fast_was_on_reg <= 1'b0;
    end else begin
      fast_was_on_reg <= fast_req;
      if (sleep_reg) begin
        // sleep clears every source flag
        pri_act_reg <= 1'b0;
        sec_act_reg <= 1'b0;
        int_stb_reg <= 1'b0;
      end else if (state_reg == ST_STEADY) begin
        pri_act_reg <= (cur_src_reg == SRC_PRI) && pri_rdy_reg;
        sec_act_reg <= (cur_src_reg == SRC_SEC);
        // fast flag waits for stability; already stable keeps it
        if (cur_src_reg == SRC_INT)
          int_stb_reg <= fast_req && fast_stb_reg && fast_was_on_reg;
        else if (cur_src_reg == SRC_PRI && pri_int)
          int_stb_reg <= fast_stb_reg;
        else
          int_stb_reg <= 1'b0;
      end
    end
  end

  // oscillator enables and gated clock enables
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pri_osc_en <= 1'b1;
      o_sec_osc_en <= 1'b0;
      o_fast_osc_en <= 1'b0;
      o_slow_src_en <= 1'b1;
      o_clk_sel <= SRC_PRI;
      o_freq_sel <= 3'h0;
      o_cpu_clk_en <= 1'b1;
      o_per_clk_en <= 1'b1;
    end else begin
      // primary stops once another source has taken over, or in sleep
      o_pri_osc_en <= !sleep_reg &&
                      (cur_src_reg == SRC_PRI || tgt_src_reg == SRC_PRI);
      o_sec_osc_en <= aux_reg[`PMCS_AUX_SECEN_BIT];
      o_fast_osc_en <= fast_req && !sleep_reg;
      o_slow_src_en <= !sleep_reg || aux_reg[`PMCS_AUX_WDT_BIT] ||
                       aux_reg[`PMCS_AUX_FSCM_BIT];
      o_clk_sel <= cur_src_reg;
      o_freq_sel <= freq;
      o_cpu_clk_en <= mux_on_reg && !sleep_reg && !idle_reg;
      o_per_clk_en <= mux_on_reg && !sleep_reg;
    end
  end

endmodule // pmcs_top

// File: sim/pmcs_chk.sv
module pmcs_chk (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic i_sleep_exec,
  input wire logic o_sec_osc_en,
  input wire logic [1:0] o_clk_sel,
  input wire logic [2:0] o_freq_sel,
  input wire logic o_cpu_clk_en,
  input wire logic o_per_clk_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic [2:0] fq_reg;
  // frequency field of the last accepted mode write
  always @(posedge i_core_clk) begin
    if (i_avs_write && !o_avs_waitrequest && i_avs_address == 2'h0) fq_reg <= i_avs_writedata[6:4];
  end
  property p_bus_ans; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");
  property p_freq; i_avs_write && !o_avs_waitrequest && i_avs_address == 2'h0 |=> ##[0:1] o_freq_sel == fq_reg;
  endproperty
  a_freq: assert property (p_freq) else $error("freq not applied");
  property p_sleep; i_sleep_exec && o_cpu_clk_en && o_per_clk_en |-> ##[1:3] !o_cpu_clk_en;
  endproperty
  a_sleep: assert property (p_sleep) else $error("cpu clock kept");
  property p_gate; o_cpu_clk_en |-> o_per_clk_en;
  endproperty
  a_gate: assert property (p_gate) else $error("cpu without peripherals");
  property p_sel_ok; o_clk_sel != 2'h3;
  endproperty
  a_sel_ok: assert property (p_sel_ok) else $error("bad mux select");
  property p_sec_en; o_clk_sel == 2'h1 |-> o_sec_osc_en;
  endproperty
  a_sec_en: assert property (p_sec_en) else $error("secondary used while off");
  property p_no_runt; $changed(o_clk_sel) |-> !$past(o_per_clk_en) && !o_per_clk_en;
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("mux moved while clocking");
  property p_new_cyc; $changed(o_clk_sel) |=> !o_per_clk_en [*3];
  endproperty
  a_new_cyc: assert property (p_new_cyc) else $error("new source gap short");
endmodule // pmcs_chk

// File: sim/pmcs_osc_model.sv
module pmcs_osc_model #(parameter int DLY = 6) (
  input wire logic i_clk,
  input wire logic i_pri_en,
  input wire logic i_sec_en,
  input wire logic i_fast_en,
  output logic o_pri_rdy,
  output logic o_secondary_run,
  output logic o_fast_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  int cp = DLY, cs = 0, cf = 0;
  // start-up counts; dropping an enable kills the source at once
  always @(posedge i_clk) begin
    cp <= i_pri_en ? (cp < DLY ? cp + 1 : cp) : 0;
    cs <= i_sec_en ? (cs < DLY ? cs + 1 : cs) : 0;
    cf <= i_fast_en ? (cf < DLY ? cf + 1 : cf) : 0;
  end
  assign o_pri_rdy = (cp >= DLY);
  assign o_secondary_run = (cs >= DLY);
  assign o_fast_ok = (cf >= DLY);
endmodule // pmcs_osc_model

// File: sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, slp = 0, wk = 0;
  logic [1:0] adr = 0;
  logic [31:0] wd = 0, q;
  wire [31:0] rdat;
  wire wreq, pri_en, sec_en, fast_en, slow_en, cpu_en, per_en, prdy, srun, fok;
  wire [1:0] csel;
  wire [2:0] fsel;
  integer seed = 32'hDF7B;
  int failures = 0, checks = 0, n;
  logic [1:0] sq[$] = '{2'h1, 2'h0, 2'h3, 2'h0, 2'h2, 2'h0};
  logic [1:0] ex;
  logic [2:0] fq;
  always #20 clk = ~clk;
  pmcs_top dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_sleep_exec(slp), .i_wake(wk), .i_pri_ready(prdy), .i_sec_running(srun),
    .i_fast_stable(fok), .o_pri_osc_en(pri_en), .o_sec_osc_en(sec_en), .o_fast_osc_en(fast_en),
    .o_slow_src_en(slow_en), .o_clk_sel(csel), .o_freq_sel(fsel), .o_cpu_clk_en(cpu_en),
    .o_per_clk_en(per_en));
  pmcs_osc_model osc_u (.i_clk(clk), .i_pri_en(pri_en), .i_sec_en(sec_en), .i_fast_en(fast_en),
    .o_pri_rdy(prdy), .o_secondary_run(srun), .o_fast_ok(fok));
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one held request; a spare edge after release keeps accesses three cycles apart
  task automatic bus(input logic [1:0] a, input logic w, input logic [7:0] d);
    adr <= a; wr <= w; rd <= !w; wd <= {24'h0, d}; n = 0;
    do begin @(posedge clk); n++; end while (wreq !== 1'h0 && n < 50);
    q = rdat;
    if (n >= 50) begin failures++; print_verdict; end
    wr <= 1'h0; rd <= 1'h0;
    @(posedge clk);
  endtask
  // waits for the mux to settle with clocks back on, then for the synced flags
  task automatic wsel(input logic [1:0] e);
    n = 0;
    while ((csel !== e || per_en !== 1'h1) && n < 300) begin @(posedge clk); n++; end
    if (n >= 300) begin failures++; print_verdict; end
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    bus(2'h0, 1'h0, 8'h00); chk("mode_rst", 32'h08, q);
    chk("cpu_rst", 1'h1, cpu_en & per_en);
    bus(2'h3, 1'h0, 8'h00); chk("unmapped", 32'h0, q);
    // secondary asked for while its oscillator is off; status bit written too
    bus(2'h0, 1'h1, 8'h05); repeat (30) @(posedge clk);
    chk("refused", 2'h0, csel);
    bus(2'h0, 1'h0, 8'h00); chk("mode_ro", 32'h09, q);
    bus(2'h0, 1'h1, 8'h00); bus(2'h1, 1'h1, 8'h05);
    foreach (sq[i]) begin
      fq = $random(seed);
      ex = sq[i][1] ? 2'h2 : sq[i];
      bus(2'h0, 1'h1, {1'h0, fq, 2'h0, sq[i]}); wsel(ex);
      chk("clk_sel", ex, csel);
      bus(2'h0, 1'h0, 8'h00);
      chk("mode", {fq, sq[i] == 2'h0, sq[i]}, {q[6:3], q[1:0]});
      chk("int_flag", ex == 2'h2 && fq != 3'h0, q[2]);
      chk("freq", fq, fsel);
      chk("fast_en", fq != 3'h0, fast_en);
      chk("pri_en", sq[i] == 2'h0, pri_en);
      chk("sec_osc", 1'h1, sec_en);
      chk("slow_en", 1'h1, slow_en);
      bus(2'h2, 1'h0, 8'h00); chk("sec_flag", sq[i] == 2'h1, q[6]);
      $display("test select %0d done", sq[i]);
    end
    // idle first, then sleep: each takes the idle bit of its own moment
    for (int i = 1; i >= 0; i--) begin
      bus(2'h0, 1'h1, {i[0], 7'h00});
      slp <= 1'h1; @(posedge clk); slp <= 1'h0;
      repeat (4) @(posedge clk);
      chk("cpu_en", 1'h0, cpu_en);
      chk("per_en", i[0], per_en);
      wk <= 1'h1; @(posedge clk); wk <= 1'h0; wsel(2'h0);
      $display("test sleep idle %0d done", i);
    end
    print_verdict;
  end
endmodule // testbench
bind pmcs_top pmcs_chk chk_u (.*);
